//--- core/nec_norm_codec.sv
`timescale 1ns/10ps
module nec_norm_codec #(
	parameter int         NB             = 44,
	parameter int         FIFO_DEPTH     = 16,
	parameter int         CODE_W         = 8,
	parameter logic [5:0] CONTEXT_OFFSET = 6'h00
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	input  wire logic              NORM_VALID,
	input  wire logic [5:0]        NORM_INDEX,
	input  wire logic              NORM_LAST,
	output logic                   NORM_READY,
	input  wire logic              TRANSIENT_FLAG,
	input  wire logic [1:0]        BANDWIDTH,
	input  wire logic [1:0]        BITRATE,
	output logic [4:0]             LUT_SYMBOL,
	output logic [5:0]             LUT_CONTEXT,
	input  wire logic [CODE_W-1:0] LUT_CTX_CODE,
	input  wire logic [3:0]        LUT_CTX_LEN,
	input  wire logic [CODE_W-1:0] LUT_RSZ_CODE,
	input  wire logic [3:0]        LUT_RSZ_LEN,
	output logic [1:0]             MODE,
	output logic                   MODE_VALID,
	output logic                   BS_VALID,
	output logic [CODE_W-1:0]      BS_CODE,
	output logic [3:0]             BS_LEN,
	input  wire logic              BS_READY,
	output logic                   ALLOC_VALID,
	output logic [7:0]             ALLOC_NORM,
	output logic                   ALLOC_LAST,
	output logic                   GROUP_ALLOC,
	output logic                   BUSY
);

	// ==================================================
	// state
	typedef struct packed {
		nec_pkg::nec_state_e  st;
		logic [NB-1:0][5:0]   norm;
		logic [19:0][12:0]    lev;
		logic [5:0]           nb;
		logic [5:0]           b;
		logic [4:0]           p;
		logic [4:0]           npts;
		logic [12:0]          acc;
		logic [12:0]          mn;
		logic [12:0]          mx;
		logic [9:0]           c_ctx;
		logic [9:0]           c_rsz;
		logic [9:0]           c_fix;
		logic [9:0]           c_pack;
		logic [1:0]           mode;
		logic [1:0]           bw;
		logic                 trans;
		logic                 norm_ready;
		logic                 mode_valid;
		logic                 group_alloc;
		logic                 alloc_valid;
		logic                 alloc_last;
		logic [7:0]           alloc_norm;
		logic [4:0]           lut_sym;
		logic [5:0]           lut_ctx;
		logic                 busy;
	} nec_core_s;

	nec_core_s                 s;
	nec_core_s                 next_s;
	logic                      push_valid;
	logic [CODE_W+3:0]         push_data;
	logic                      push_ready;
	logic [CODE_W+3:0]         bs_word;
	logic [4:0]                sym;
	logic [10:0]               fc;
	logic [12:0]               lvl;
	logic [12:0]               acc_new;
	logic signed [12:0]        a;
	logic signed [12:0]        c;
	logic [12:0]               adj;
	logic [9:0]                best;

	// ==================================================
	// helpers
	function automatic logic [4:0] diff_sym(input logic [NB-1:0][5:0] n, input logic [5:0] b);
		diff_sym = 5'(n[b] - n[b-6'h01] + nec_pkg::SYM_OFFSET);
	endfunction

	function automatic logic [5:0] diff_ctx(input logic [NB-1:0][5:0] n, input logic [5:0] b);
		if (b == 6'h01)
			diff_ctx = n[0] - CONTEXT_OFFSET;
		else
			diff_ctx = n[b-6'h01] - n[b-6'h02];
	endfunction

	// point whose band set holds band b; 20 when none
	function automatic logic [4:0] point_of(input logic [5:0] b);
		point_of = 5'h14;
		for (int i = nec_pkg::NPTS_MAX - 1; i >= 0; i--)
		begin
			if (b <= nec_pkg::SET_END[i])
				point_of = 5'(i);
		end
	endfunction

	function automatic logic [12:0] band_adj(input nec_core_s q, input logic [5:0] b);
		logic [4:0] pt;
		pt = point_of(b);
		band_adj = (pt < q.npts) ? q.lev[pt] : 13'h0000;
	endfunction

	// ==================================================
	// bitstream queue
	nec_fifo #(
		.W     (CODE_W + 4),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (push_valid),
		.in_data   (push_data),
		.in_ready  (push_ready),
		.out_valid (BS_VALID),
		.out_data  (bs_word),
		.out_ready (BS_READY)
	);

	assign BS_LEN      = bs_word[CODE_W+3:CODE_W];
	assign BS_CODE     = bs_word[CODE_W-1:0];
	assign NORM_READY  = s.norm_ready;
	assign LUT_SYMBOL  = s.lut_sym;
	assign LUT_CONTEXT = s.lut_ctx;
	assign MODE        = s.mode;
	assign MODE_VALID  = s.mode_valid;
	assign ALLOC_VALID = s.alloc_valid;
	assign ALLOC_NORM  = s.alloc_norm;
	assign ALLOC_LAST  = s.alloc_last;
	assign GROUP_ALLOC = s.group_alloc;
	assign BUSY        = s.busy;

	// ==================================================
	// next state
	always_comb
	begin
		next_s             = s;
		next_s.mode_valid  = 1'b0;
		next_s.alloc_valid = 1'b0;
		next_s.alloc_last  = 1'b0;
		push_valid         = 1'b0;
		push_data          = '0;
		sym                = diff_sym(s.norm, s.b);
		fc                 = nec_pkg::fix_code(sym);
		lvl                = '0;
		acc_new            = '0;
		a                  = '0;
		c                  = '0;
		adj                = '0;
		best               = s.c_ctx;
		case (s.st)
			nec_pkg::ST_LOAD:
			begin
				if (NORM_VALID && s.norm_ready)
				begin
					if (s.b == 6'h00)
					begin
						next_s.trans = TRANSIENT_FLAG;
						next_s.bw    = BANDWIDTH;
						case (BITRATE)
							nec_pkg::RATE_24K4: next_s.npts = nec_pkg::NPTS_24K4;
							nec_pkg::RATE_32K:  next_s.npts = nec_pkg::NPTS_32K;
							default:            next_s.npts = nec_pkg::NPTS_64K;
						endcase
						next_s.group_alloc = (BANDWIDTH == nec_pkg::BW_WB) && !TRANSIENT_FLAG
							&& (BITRATE == nec_pkg::RATE_24K4 || BITRATE == nec_pkg::RATE_32K);
					end
					next_s.norm[s.b] = NORM_INDEX;
					if (NORM_LAST || s.b == 6'(NB - 1))
					begin
						next_s.nb     = s.b + 6'h01;
						next_s.b      = 6'h01;
						next_s.c_ctx  = '0;
						next_s.c_rsz  = '0;
						next_s.c_fix  = '0;
						next_s.c_pack = '0;
						next_s.st     = (s.b == 6'h00) ? nec_pkg::ST_PICK : nec_pkg::ST_COST_A;
					end
					else
						next_s.b = s.b + 6'h01;
				end
			end
			nec_pkg::ST_COST_A:
			begin
				next_s.c_fix   = s.c_fix + 10'(fc[10:7]);
				next_s.c_pack  = s.c_pack + 10'(nec_pkg::LEN_FIELD);
				next_s.lut_sym = sym;
				next_s.lut_ctx = diff_ctx(s.norm, s.b);
				next_s.st      = nec_pkg::ST_COST_B;
			end
			nec_pkg::ST_COST_B:
			begin
				// table answers to the address registered last cycle
				next_s.c_ctx = s.c_ctx + 10'(LUT_CTX_LEN);
				next_s.c_rsz = s.c_rsz + 10'(LUT_RSZ_LEN);
				if (s.b == s.nb - 6'h01)
					next_s.st = nec_pkg::ST_PICK;
				else
				begin
					next_s.b  = s.b + 6'h01;
					next_s.st = nec_pkg::ST_COST_A;
				end
			end
			nec_pkg::ST_PICK:
			begin
				// ties go to the lower mode number
				next_s.mode = nec_pkg::MODE_CTX;
				if (s.c_rsz < best)
				begin
					best        = s.c_rsz;
					next_s.mode = nec_pkg::MODE_RSZ;
				end
				if (s.c_fix < best)
				begin
					best        = s.c_fix;
					next_s.mode = nec_pkg::MODE_FIX;
				end
				if (s.c_pack < best)
					next_s.mode = nec_pkg::MODE_PACK;
				next_s.mode_valid = 1'b1;
				next_s.b          = 6'h01;
				next_s.st         = nec_pkg::ST_HDR_MODE;
			end
			nec_pkg::ST_HDR_MODE:
			begin
				push_valid = 1'b1;
				push_data  = {nec_pkg::LEN_MODE, CODE_W'(s.mode)};
				if (push_ready)
					next_s.st = nec_pkg::ST_HDR_FIRST;
			end
			nec_pkg::ST_HDR_FIRST:
			begin
				push_valid = 1'b1;
				push_data  = {nec_pkg::LEN_FIELD, CODE_W'(s.norm[0][4:0])};
				if (push_ready)
				begin
					next_s.b  = 6'h00;
					next_s.p  = 5'h00;
					next_s.acc = '0;
					if (s.nb > 6'h01)
					begin
						next_s.b  = 6'h01;
						next_s.st = nec_pkg::ST_EMIT_A;
					end
					else
						next_s.st = (s.bw == nec_pkg::BW_FB) ? nec_pkg::ST_MAP
							: nec_pkg::ST_OUT;
				end
			end
			nec_pkg::ST_EMIT_A:
			begin
				next_s.lut_sym = sym;
				next_s.lut_ctx = diff_ctx(s.norm, s.b);
				next_s.st      = nec_pkg::ST_EMIT_B;
			end
			nec_pkg::ST_EMIT_B:
			begin
				// code right aligned, leftmost printed bit sent first
				push_valid = 1'b1;
				case (s.mode)
					nec_pkg::MODE_CTX: push_data = {LUT_CTX_LEN, LUT_CTX_CODE};
					nec_pkg::MODE_RSZ: push_data = {LUT_RSZ_LEN, LUT_RSZ_CODE};
					nec_pkg::MODE_FIX: push_data = {fc[10:7], CODE_W'(fc[6:0])};
					default:           push_data = {nec_pkg::LEN_FIELD, CODE_W'(sym)};
				endcase
				if (push_ready)
				begin
					if (s.b == s.nb - 6'h01)
					begin
						next_s.b  = 6'h00;
						next_s.st = (s.bw == nec_pkg::BW_FB) ? nec_pkg::ST_MAP
							: nec_pkg::ST_OUT;
					end
					else
					begin
						next_s.b  = s.b + 6'h01;
						next_s.st = nec_pkg::ST_EMIT_A;
					end
				end
			end
			nec_pkg::ST_MAP:
			begin
				// levels carry two fraction bits, so a mean of four is exact
				if (s.trans)
				begin
					for (int k = 0; k < 4; k++)
						lvl = lvl + 13'(s.norm[{s.b[5:2], 2'(k)}]);
				end
				else
					lvl = {5'h00, s.norm[s.b], 2'h0};
				acc_new = s.acc + lvl;
				next_s.acc = acc_new;
				if (s.b == nec_pkg::SET_END[s.p])
				begin
					next_s.lev[s.p] = acc_new / 13'(nec_pkg::SET_DIV[s.p])
						+ {7'h00, nec_pkg::SET_ADD[s.p], 2'h0};
					next_s.acc = '0;
					next_s.p   = s.p + 5'h01;
					if (s.p + 5'h01 == s.npts)
					begin
						next_s.p  = 5'h01;
						next_s.st = nec_pkg::ST_FWD;
					end
				end
				next_s.b = s.b + 6'h01;
			end
			nec_pkg::ST_FWD:
			begin
				a = $signed(s.lev[s.p]);
				c = $signed(s.lev[s.p-5'h01]) - $signed(nec_pkg::FWD_DROP);
				next_s.lev[s.p] = (c > a) ? c : a;
				if (s.p == s.npts - 5'h01)
				begin
					next_s.p  = s.npts - 5'h02;
					next_s.st = nec_pkg::ST_BWD;
				end
				else
					next_s.p = s.p + 5'h01;
			end
			nec_pkg::ST_BWD:
			begin
				a = $signed(s.lev[s.p]);
				c = $signed(s.lev[s.p+5'h01]) - $signed(nec_pkg::BWD_DROP);
				next_s.lev[s.p] = (c > a) ? c : a;
				if (s.p == 5'h00)
					next_s.st = nec_pkg::ST_THR;
				else
					next_s.p = s.p - 5'h01;
			end
			nec_pkg::ST_THR:
			begin
				for (int i = 0; i < nec_pkg::NPTS_MAX; i++)
				begin
					a = $signed(s.lev[i]);
					c = $signed({7'h00, nec_pkg::PTHR[i], 2'h0});
					next_s.lev[i] = {7'h00, nec_pkg::SET_ADD[i], 2'h0}
						- 13'((c > a) ? c : a);
				end
				next_s.st = nec_pkg::ST_RANGE;
			end
			nec_pkg::ST_RANGE:
			begin
				next_s.mn = s.lev[0];
				next_s.mx = s.lev[0];
				for (int i = 1; i < nec_pkg::NPTS_MAX; i++)
				begin
					if (5'(i) < s.npts)
					begin
						if ($signed(s.lev[i]) < $signed(next_s.mn))
							next_s.mn = s.lev[i];
						if ($signed(s.lev[i]) > $signed(next_s.mx))
							next_s.mx = s.lev[i];
					end
				end
				next_s.p  = 5'h00;
				next_s.st = nec_pkg::ST_SCALE;
			end
			nec_pkg::ST_SCALE:
			begin
				// flat spectrum has no range: every point scales to zero
				lvl = s.mx - s.mn;
				acc_new = s.lev[s.p] - s.mn;
				if (lvl == 13'h0000)
					next_s.lev[s.p] = '0;
				else
					next_s.lev[s.p] = 13'((acc_new * nec_pkg::SCALE_TOP) / lvl);
				if (s.p == s.npts - 5'h01)
				begin
					next_s.b  = 6'h00;
					next_s.st = nec_pkg::ST_OUT;
				end
				else
					next_s.p = s.p + 5'h01;
			end
			nec_pkg::ST_OUT:
			begin
				if (s.bw == nec_pkg::BW_FB)
				begin
					if (s.trans)
					begin
						for (int k = 0; k < 4; k++)
							adj = adj + band_adj(s, {s.b[5:2], 2'(k)});
						adj = adj >> nec_pkg::FRAC;
					end
					else
						adj = band_adj(s, s.b);
				end
				next_s.alloc_valid = 1'b1;
				next_s.alloc_norm  = 8'({s.norm[s.b], 2'h0} + adj);
				next_s.alloc_last  = (s.b == s.nb - 6'h01);
				if (s.b == s.nb - 6'h01)
				begin
					next_s.b  = 6'h00;
					next_s.st = nec_pkg::ST_LOAD;
				end
				else
					next_s.b = s.b + 6'h01;
			end
			default:
				next_s.st = nec_pkg::ST_LOAD;
		endcase
		next_s.norm_ready = (next_s.st == nec_pkg::ST_LOAD);
		next_s.busy       = (next_s.st != nec_pkg::ST_LOAD);
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			s <= '0;
		else
			s <= next_s;
	end

endmodule

//--- core/nec_pkg.sv
package nec_pkg;

	// ==================================================
	// coding modes and frame configuration codes
	localparam logic [1:0] MODE_CTX  = 2'h0;
	localparam logic [1:0] MODE_RSZ  = 2'h1;
	localparam logic [1:0] MODE_FIX  = 2'h2;
	localparam logic [1:0] MODE_PACK = 2'h3;
	localparam logic [1:0] BW_WB     = 2'h0;
	localparam logic [1:0] BW_SWB    = 2'h1;
	localparam logic [1:0] BW_FB     = 2'h2;
	localparam logic [1:0] RATE_24K4 = 2'h0;
	localparam logic [1:0] RATE_32K  = 2'h1;
	localparam logic [1:0] RATE_64K  = 2'h2;

	// ==================================================
	// field sizes and coding constants
	localparam logic [3:0] LEN_MODE   = 4'h2;
	localparam logic [3:0] LEN_FIELD  = 4'h5;
	localparam logic [5:0] SYM_OFFSET = 6'h0F;
	localparam int         NPTS_MAX   = 20;
	localparam logic [4:0] NPTS_24K4  = 5'h11;
	localparam logic [4:0] NPTS_32K   = 5'h12;
	localparam logic [4:0] NPTS_64K   = 5'h14;

	// ==================================================
	// auditory point tables, element 0 is point 0
	localparam logic [19:0][5:0] SET_END = {6'h2B, 6'h22, 6'h1D, 6'h1A, 6'h17, 6'h13, 6'h11,
		6'h0F, 6'h0D, 6'h0B, 6'h09, 6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
	localparam logic [19:0][3:0] SET_DIV = {4'h9, 4'h5, 4'h3, 4'h3, 4'h4, 4'h2, 4'h2, 4'h2,
		4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
	localparam logic [19:0][3:0] SET_ADD = {4'h8, 4'h7, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h4,
		4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3};
	localparam logic [19:0][3:0] PTHR    = {4'hB, 4'h7, 4'h5, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3,
		4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h6, 4'h8};

	// ==================================================
	// adjustment arithmetic: two fraction bits, floor rounding
	localparam int          FRAC      = 2;
	localparam logic [12:0] FWD_DROP  = 13'h0010;
	localparam logic [12:0] BWD_DROP  = 13'h0020;
	localparam logic [12:0] SCALE_TOP = 13'h0010;

	typedef enum logic [3:0] {
		ST_LOAD      = 4'h0,
		ST_COST_A    = 4'h1,
		ST_COST_B    = 4'h2,
		ST_PICK      = 4'h3,
		ST_HDR_MODE  = 4'h4,
		ST_HDR_FIRST = 4'h5,
		ST_EMIT_A    = 4'h6,
		ST_EMIT_B    = 4'h7,
		ST_MAP       = 4'h8,
		ST_FWD       = 4'h9,
		ST_BWD       = 4'hA,
		ST_THR       = 4'hB,
		ST_RANGE     = 4'hC,
		ST_SCALE     = 4'hD,
		ST_OUT       = 4'hE
	} nec_state_e;

	// fixed table code: {length, code right aligned}
	function automatic logic [10:0] fix_code(input logic [4:0] s);
		case (s[4:2])
			3'h0:    fix_code = {4'h7, s[1:0], 5'h1A};
			3'h1:    fix_code = {4'h7, s[1:0], 5'h1B};
			3'h2:    fix_code = {4'h6, 1'h0, s[1:0], 4'hC};
			3'h3:    fix_code = s[1] ? {4'h3, 4'h0, s[1:0], 1'h0} : {4'h4, 3'h0, s[1:0], 2'h2};
			3'h4:    fix_code = s[1] ? {4'h4, 3'h0, s[1:0], 2'h2} : {4'h3, 4'h0, s[1:0], 1'h0};
			3'h5:    fix_code = {4'h6, 1'h0, s[1:0], 4'hE};
			3'h6:    fix_code = {4'h7, s[1:0], 5'h1E};
			default: fix_code = {4'h7, s[1:0], 5'h1F};
		endcase
	endfunction

endpackage

//--- core/nec_fifo.sv
`timescale 1ns/10ps
module nec_fifo #(
	parameter int W     = 12,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	// ==================================================
	// shifting queue: head is always entry 0, so outputs are flops
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [DEPTH-1:0]        vld;
	} nec_fifo_s;

	nec_fifo_s s;
	nec_fifo_s next_s;
	logic      placed;

	// full refuses even when popping, keeps ready free of out_ready
	assign in_ready  = !s.vld[DEPTH-1];
	assign out_valid = s.vld[0];
	assign out_data  = s.mem[0];

	always_comb
	begin
		next_s = s;
		placed = 1'b0;
		if (s.vld[0] && out_ready)
		begin
			for (int i = 0; i < DEPTH - 1; i++)
			begin
				next_s.mem[i] = s.mem[i+1];
				next_s.vld[i] = s.vld[i+1];
			end
			next_s.vld[DEPTH-1] = 1'b0;
		end
		if (in_valid && !s.vld[DEPTH-1])
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				if (!placed && !next_s.vld[i])
				begin
					next_s.mem[i] = in_data;
					next_s.vld[i] = 1'b1;
					placed        = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

endmodule

//--- sim/nec_checker.sv
`timescale 1ns/10ps
module nec_checker #(
	parameter int CODE_W = 8
) (
	input wire logic              SYS_CLK,
	input wire logic              RST,
	input wire logic              NORM_VALID,
	input wire logic              NORM_LAST,
	input wire logic              NORM_READY,
	input wire logic [1:0]        MODE,
	input wire logic              MODE_VALID,
	input wire logic              BS_VALID,
	input wire logic [CODE_W-1:0] BS_CODE,
	input wire logic [3:0]        BS_LEN,
	input wire logic              BS_READY,
	input wire logic              ALLOC_VALID,
	input wire logic              ALLOC_LAST,
	input wire logic              GROUP_ALLOC,
	input wire logic              BUSY
);
	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	// ==========
	// scheme choice and fields
	chk_mode_strobe: assert property (!$stable(MODE) |-> MODE_VALID ##1 !MODE_VALID)
		else $error("mode moved without a single strobe");
	chk_mode_field: assert property (BS_VALID && BS_LEN == 4'h2 |-> BS_CODE == CODE_W'(MODE))
		else $error("two-bit field differs from mode");
	chk_pack_len: assert property (MODE == 2'h3 && BS_VALID |-> BS_LEN == 4'h2 || BS_LEN == 4'h5)
		else $error("packing field not five bits");
	chk_fix_len: assert property (MODE == 2'h2 && BS_VALID |-> BS_LEN inside {[4'h2:4'h7]})
		else $error("fixed table field of bad length");
	// a stalled head must not slip, or the writer loses bits
	chk_head_hold: assert property (BS_VALID && !BS_READY |=> BS_VALID && $stable(BS_CODE) && $stable(BS_LEN))
		else $error("bitstream head changed while stalled");

	// ==========
	// frame flow
	chk_frame_end: assert property (NORM_VALID && NORM_READY && NORM_LAST |=> !NORM_READY && BUSY)
		else $error("last norm did not close the frame");
	chk_last_pulse: assert property (ALLOC_LAST |-> ALLOC_VALID ##1 !ALLOC_VALID)
		else $error("last flag outside a single norm pulse");
	chk_release: assert property (ALLOC_VALID && ALLOC_LAST |-> ##[1:2] NORM_READY)
		else $error("no return to idle after last norm");
	chk_group_hold: assert property (!$stable(GROUP_ALLOC) |-> $past(NORM_VALID && NORM_READY))
		else $error("group flag moved without a norm taken");
endmodule

//--- sim/nec_partner.sv
`timescale 1ns/10ps
module nec_partner (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [4:0] sym,
	input  wire logic [5:0] ctx,
	input  wire logic       stall,
	input  wire logic       slow,
	input  wire logic [1:0] cheap,
	output logic [7:0]      ctx_code,
	output logic [3:0]      ctx_len,
	output logic [7:0]      rsz_code,
	output logic [3:0]      rsz_len,
	output logic            bs_ready
);
	// ==========
	// stand-in codebooks: codes expose the whole lookup address
	assign ctx_code = {2'h0, ctx};
	assign rsz_code = {3'h0, sym};
	// cheap table makes its scheme win or tie the cost race
	assign ctx_len  = cheap[0] ? 4'h3 : 4'h8;
	assign rsz_len  = cheap[1] ? 4'h3 : 4'h8;
	// ==========
	// writer: full rate, every other cycle, or held off
	always_ff @(posedge clk)
		if (rst)
			bs_ready <= 1'h0;
		else
			bs_ready <= !stall && (!slow || !bs_ready);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam int CODE_W = 8;
	logic              SYS_CLK = 1'h0;
	logic              RST = 1'h1;
	logic              NORM_VALID = 1'h0;
	logic              NORM_LAST = 1'h0;
	logic              TRANSIENT_FLAG = 1'h0;
	logic              stall = 1'h0;
	logic              slow = 1'h0;
	logic [5:0]        NORM_INDEX = 6'h00;
	logic [1:0]        BANDWIDTH = 2'h0;
	logic [1:0]        BITRATE = 2'h0;
	logic [1:0]        cheap = 2'h0;
	logic [3:0]        LUT_CTX_LEN, LUT_RSZ_LEN;
	logic              NORM_READY, MODE_VALID, BS_VALID, BS_READY;
	logic              ALLOC_VALID, ALLOC_LAST, GROUP_ALLOC, BUSY;
	logic [4:0]        LUT_SYMBOL;
	logic [5:0]        LUT_CONTEXT;
	logic [CODE_W-1:0] LUT_CTX_CODE, LUT_RSZ_CODE, BS_CODE;
	logic [3:0]        BS_LEN;
	logic [1:0]        MODE;
	logic [7:0]        ALLOC_NORM;
	int                failures = 0;
	int                n_checks = 0;
	int                cyc = 0;
	int                nrm[$];
	int                eal[44];
	logic [11:0]       ebs[$];
	logic [11:0]       gbs[$];
	logic [8:0]        gal[$];

	nec_norm_codec #(.CODE_W(CODE_W)) dut (
		.SYS_CLK, .RST, .NORM_VALID, .NORM_INDEX, .NORM_LAST, .NORM_READY, .TRANSIENT_FLAG,
		.BANDWIDTH, .BITRATE, .LUT_SYMBOL, .LUT_CONTEXT, .LUT_CTX_CODE, .LUT_CTX_LEN,
		.LUT_RSZ_CODE, .LUT_RSZ_LEN, .MODE, .MODE_VALID, .BS_VALID, .BS_CODE, .BS_LEN,
		.BS_READY, .ALLOC_VALID, .ALLOC_NORM, .ALLOC_LAST, .GROUP_ALLOC, .BUSY
	);
	nec_partner partner (
		.clk(SYS_CLK), .rst(RST), .sym(LUT_SYMBOL), .ctx(LUT_CONTEXT), .stall, .slow, .cheap,
		.ctx_code(LUT_CTX_CODE), .ctx_len(LUT_CTX_LEN), .rsz_code(LUT_RSZ_CODE),
		.rsz_len(LUT_RSZ_LEN), .bs_ready(BS_READY)
	);

	initial
		forever #2 SYS_CLK = ~SYS_CLK;

	// ==========
	// capture and hang guard
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (BS_VALID === 1'h1 && BS_READY === 1'h1)
			gbs.push_back({BS_LEN, BS_CODE});
		if (ALLOC_VALID === 1'h1)
			gal.push_back({ALLOC_LAST, ALLOC_NORM});
		if (cyc == 30000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	// ==========
	// frame driver and shared judging
	task automatic run(input logic tr, input logic [1:0] bw, input logic [1:0] rt);
		int k;
		gbs.delete();
		gal.delete();
		foreach (nrm[b])
			eal[b] = 4 * nrm[b];
		k = 0;
		while (NORM_READY !== 1'h1 && k < 500)
		begin
			@(negedge SYS_CLK);
			k++;
		end
		for (int b = 0; b < nrm.size(); b++)
		begin
			@(negedge SYS_CLK);
			NORM_VALID = 1'h1;
			NORM_INDEX = 6'(nrm[b]);
			NORM_LAST = (b == nrm.size() - 1);
			TRANSIENT_FLAG = tr;
			BANDWIDTH = bw;
			BITRATE = rt;
		end
		@(negedge SYS_CLK);
		NORM_VALID = 1'h0;
		NORM_LAST = 1'h0;
		k = 0;
		while ((gal.size() < nrm.size() || BS_VALID !== 1'h0 || NORM_READY !== 1'h1) && k < 5000)
		begin
			@(negedge SYS_CLK);
			k++;
		end
	endtask

	task automatic hdr(input logic [1:0] m);
		ebs = {};
		ebs.push_back({nec_pkg::LEN_MODE, CODE_W'(m)});
		ebs.push_back({nec_pkg::LEN_FIELD, 8'(nrm[0] % 32)});
	endtask

	task automatic syms5();
		for (int b = 1; b < nrm.size(); b++)
			ebs.push_back({nec_pkg::LEN_FIELD, 8'(nrm[b] - nrm[b-1] + 15)});
	endtask

	task automatic fin(input logic [1:0] m, input logic grp);
		cmp("mode", 16'(m), 16'(MODE));
		cmp("group alloc", 16'(grp), 16'(GROUP_ALLOC));
		cmp("field count", 16'(ebs.size()), 16'(gbs.size()));
		for (int i = 0; i < ebs.size() && i < gbs.size(); i++)
			cmp("field", 16'(ebs[i]), 16'(gbs[i]));
		cmp("alloc count", 16'(nrm.size()), 16'(gal.size()));
		foreach (gal[i])
			cmp("alloc", {7'h00, i == nrm.size() - 1, eal[i][7:0]}, {7'h00, gal[i]});
	endtask

	task automatic exp_fb(input logic tr, input int np);
		int lv[20];
		int bl[44];
		int pt[44];
		int s, lo, mn, mx;
		for (int b = 0; b < 44; b++)
			bl[b] = tr ? nrm[b/4*4] + nrm[b/4*4+1] + nrm[b/4*4+2] + nrm[b/4*4+3] : 4 * nrm[b];
		lo = 0;
		for (int p = 0; p < 20; p++)
		begin
			s = 0;
			for (int b = lo; b <= int'(nec_pkg::SET_END[p]); b++)
			begin
				s += bl[b];
				pt[b] = p;
			end
			lo = int'(nec_pkg::SET_END[p]) + 1;
			lv[p] = s / int'(nec_pkg::SET_DIV[p]) + 4 * int'(nec_pkg::SET_ADD[p]);
		end
		for (int p = 1; p < np; p++)
			if (lv[p] < lv[p-1] - 16)
				lv[p] = lv[p-1] - 16;
		for (int p = np - 2; p >= 0; p--)
			if (lv[p] < lv[p+1] - 32)
				lv[p] = lv[p+1] - 32;
		mn = 9999;
		mx = -9999;
		for (int p = 0; p < np; p++)
		begin
			s = 4 * int'(nec_pkg::PTHR[p]);
			lv[p] = 4 * int'(nec_pkg::SET_ADD[p]) - (lv[p] > s ? lv[p] : s);
			mn = lv[p] < mn ? lv[p] : mn;
			mx = lv[p] > mx ? lv[p] : mx;
		end
		for (int b = 0; b < 44; b++)
			bl[b] = (pt[b] >= np || mx == mn) ? 0 : 16 * (lv[pt[b]] - mn) / (mx - mn);
		for (int b = 0; b < 44; b++)
			eal[b] = 4 * nrm[b] + (tr ? (bl[b/4*4] + bl[b/4*4+1] + bl[b/4*4+2] + bl[b/4*4+3]) / 4
				: bl[b]);
	endtask

	// ==========
	// scenarios
	task automatic t_fix();
		logic [11:0] fx[8] = '{12'h306, 12'h300, 12'h304, 12'h302, 12'h71A, 12'h77F, 12'h402,
			12'h60C};
		nrm = '{20, 20, 21, 20, 22, 7, 23, 20, 13};
		hdr(nec_pkg::MODE_FIX);
		foreach (fx[i])
			ebs.push_back(fx[i]);
		run(1'h0, nec_pkg::BW_WB, nec_pkg::RATE_24K4);
		fin(nec_pkg::MODE_FIX, 1'h1);
	endtask

	task automatic t_pack();
		nrm = '{30, 15, 30, 15, 30};
		hdr(nec_pkg::MODE_PACK);
		syms5();
		run(1'h0, nec_pkg::BW_SWB, nec_pkg::RATE_32K);
		fin(nec_pkg::MODE_PACK, 1'h0);
	endtask

	// three-way tie at nine bits: lowest scheme must win
	task automatic t_ctx();
		nrm = '{5, 7, 6, 6};
		cheap = 2'h3;
		hdr(nec_pkg::MODE_CTX);
		ebs.push_back(12'h305);
		ebs.push_back(12'h302);
		ebs.push_back(12'h33F);
		run(1'h1, nec_pkg::BW_WB, nec_pkg::RATE_32K);
		fin(nec_pkg::MODE_CTX, 1'h0);
	endtask

	task automatic t_rsz();
		nrm = '{5, 6, 4, 8};
		cheap = 2'h2;
		hdr(nec_pkg::MODE_RSZ);
		ebs.push_back(12'h310);
		ebs.push_back(12'h30D);
		ebs.push_back(12'h313);
		run(1'h0, nec_pkg::BW_WB, nec_pkg::RATE_64K);
		cheap = 2'h0;
		fin(nec_pkg::MODE_RSZ, 1'h0);
	endtask

	// without transient a stalled writer fills the fifo on the long frame; with transient the writer takes every other cycle
	task automatic t_fb(input logic tr, input logic [1:0] rt, input int np);
		nrm.delete();
		for (int b = 0; b < 44; b++)
			nrm.push_back(b % 2 ? 15 : 30);
		stall = !tr;
		slow = tr;
		fork
			begin
				repeat (400) @(negedge SYS_CLK);
				stall = 1'h0;
			end
		join_none
		hdr(nec_pkg::MODE_PACK);
		syms5();
		run(tr, nec_pkg::BW_FB, rt);
		exp_fb(tr, np);
		slow = 1'h0;
		fin(nec_pkg::MODE_PACK, 1'h0);
	endtask

	initial
	begin
		repeat (3) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		cmp("ready in reset", 16'h0000, 16'(NORM_READY));
		cmp("alloc in reset", 16'h0000, 16'({BS_VALID, ALLOC_VALID, MODE_VALID, BUSY}));
		@(posedge SYS_CLK);
		@(negedge SYS_CLK);
		RST = 1'h0;
		@(negedge SYS_CLK);
		cmp("ready after reset", 16'h0001, 16'(NORM_READY));
		t_fix();
		t_pack();
		t_ctx();
		t_rsz();
		t_fb(1'h0, nec_pkg::RATE_64K, 20);
		t_fb(1'h1, nec_pkg::RATE_24K4, 17);
		give_verdict();
	end
endmodule

bind nec_norm_codec nec_checker #(.CODE_W(CODE_W)) chk (
	.SYS_CLK, .RST, .NORM_VALID, .NORM_LAST, .NORM_READY, .MODE, .MODE_VALID, .BS_VALID,
	.BS_CODE, .BS_LEN, .BS_READY, .ALLOC_VALID, .ALLOC_LAST, .GROUP_ALLOC, .BUSY
);
